//--- logic/dcc_cfg.svh
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// Register byte offsets
`define DCC_OFF_CTRL 8'h00
`define DCC_OFF_FLAG 8'h04
`define DCC_OFF_ENA 8'h08
`define DCC_OFF_IRQCTL 8'h0c
`define DCC_OFF_DIR 8'h10
`define DCC_OFF_CONV 8'h14
`define DCC_OFF_PORT 8'h18

// Control register fields
`define DCC_B_CMP2_RES 7
`define DCC_B_CMP1_RES 6
`define DCC_B_CMP2_INV 5
`define DCC_B_CMP1_INV 4
`define DCC_B_SWITCH 3
`define DCC_MODE_HI 2
`define DCC_MODE_LO 0

// Flag, enable and global bits
`define DCC_B_IRQ_FLAG 6
`define DCC_B_IRQ_ENA 6
`define DCC_B_PERIPH_ENA 6
`define DCC_B_GLOBAL_ENA 7

// Modes
`define DCC_MODE_OFF 3'h7
`define DCC_MODE_MUX4 3'h6
`define DCC_MODE_PIN_A 3'h3
`define DCC_MODE_PIN_B 3'h5

// Reset values
`define DCC_RST_CTRL 8'h07
`define DCC_RST_DIR 7'h7f
`define DCC_RST_CONV 4'h0
`define DCC_RST_BYTE 8'h00

// Converter config bits 3:0
`define DCC_CONV_HI 3
`define DCC_CONV_LO 0

`endif

//--- logic/dcc_pkg.sv
package dcc_pkg;

  typedef logic [7:0] dcc_byte_t;
  typedef logic [2:0] dcc_mode_t;
  typedef logic [6:0] dcc_port_t;

  // Which comparator inverting-input pin is in use: direct outside the four-input mode, a line pair in it
  typedef enum logic [1:0] {
    DCC_NEG_DIRECT,
    DCC_NEG_LINE56,
    DCC_NEG_LINE34
  } dcc_negsel_t;

endpackage : dcc_pkg

//--- logic/dcc_top.sv
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "dcc_cfg.svh"
module dcc_top
  import dcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmp1_above_i,
  input wire logic cmp2_above_i,
  input wire logic [6:0] portf_pin_i,
  output logic [6:0] portf_out_o,
  output logic [6:0] portf_oe_n_o,
  output logic cmp1_on_o,
  output logic cmp2_on_o,
  output logic [1:0] cmp_neg_sel_o,
  output logic ref_to_pos_o,
  output logic [3:0] analog_line_o,
  output logic irq_o,
  output logic wake_o
);

  // Result after inversion; forced low while off
  function automatic logic shape_result(input logic raw, input logic inv,
                                        input logic off);
    shape_result = off ? 1'b0 : (raw ^ inv);
  endfunction : shape_result

  function automatic logic is_offset(input logic [7:0] adr,
                                     input logic [7:0] off);
    is_offset = (adr == off);
  endfunction : is_offset

  dcc_byte_t comparator_control_q;
  logic flag_q;
  logic ena_q;
  logic periph_ena_q;
  logic global_ena_q;
  dcc_port_t portf_direction_q;
  dcc_port_t port_latch_q;
  logic [3:0] analog_port_config_q;
  logic [1:0] cap_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  dcc_port_t pin_s1_q;
  dcc_port_t pin_s2_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic irq_q;
  logic wake_q;
  logic [6:0] out_q;
  logic [6:0] oe_n_q;
  logic cmp1_on_q;
  logic cmp2_on_q;
  logic [1:0] neg_q;
  logic ref_q;
  logic [3:0] analog_q;

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = is_offset(wb_adr_i, `DCC_OFF_CTRL);
  wire hit_flag = is_offset(wb_adr_i, `DCC_OFF_FLAG);
  wire hit_ena = is_offset(wb_adr_i, `DCC_OFF_ENA);
  wire hit_irqc = is_offset(wb_adr_i, `DCC_OFF_IRQCTL);
  wire hit_dir = is_offset(wb_adr_i, `DCC_OFF_DIR);
  wire hit_conv = is_offset(wb_adr_i, `DCC_OFF_CONV);
  wire hit_port = is_offset(wb_adr_i, `DCC_OFF_PORT);
  wire ctrl_access = req & hit_ctrl;
  wire [7:0] wbyte = wb_dat_i[7:0];

  // Mode decode
  wire dcc_mode_t mode = comparator_control_q[`DCC_MODE_HI:`DCC_MODE_LO];
  wire mode_off = (mode == `DCC_MODE_OFF);
  wire mode_mux4 = (mode == `DCC_MODE_MUX4);
  wire mode_pin = (mode == `DCC_MODE_PIN_A) | (mode == `DCC_MODE_PIN_B);
  wire inv1 = comparator_control_q[`DCC_B_CMP1_INV];
  wire inv2 = comparator_control_q[`DCC_B_CMP2_INV];

  wire res1 = shape_result(sync2_q[0], inv1, mode_off);
  wire res2 = shape_result(sync2_q[1], inv2, mode_off);
  wire [1:0] res = {res2, res1};

  wire pin1 = shape_result(cmp1_above_i, inv1, mode_off);
  wire pin2 = shape_result(cmp2_above_i, inv2, mode_off);

  wire mismatch = (res != cap_q);

  wire flag_wr = wr & hit_flag;
  wire flag_d = mismatch | (flag_wr ? wbyte[`DCC_B_IRQ_FLAG] : flag_q);

  wire dcc_byte_t ctrl_d = (wr & hit_ctrl) ?
    {2'h0, wbyte[`DCC_B_CMP2_INV:`DCC_MODE_LO]} :
    {2'h0, comparator_control_q[`DCC_B_CMP2_INV:`DCC_MODE_LO]};

  wire [3:0] analog_d = ~analog_port_config_q;
  wire dcc_port_t port_rd = pin_s2_q & ~{1'b0, analog_d, 2'b00};

  wire dcc_negsel_t neg_d = !mode_mux4 ? DCC_NEG_DIRECT :
    (comparator_control_q[`DCC_B_SWITCH] ? DCC_NEG_LINE34 : DCC_NEG_LINE56);

  // pin drive of lines 1 and 2
  wire dcc_port_t out_d = mode_pin ?
    {port_latch_q[6:2], pin2, pin1} : port_latch_q;

  wire irq_d = flag_q & ena_q & periph_ena_q & global_ena_q;

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = `DCC_RST_BYTE;
    if (hit_ctrl) begin
      rd_byte = {res, comparator_control_q[`DCC_B_CMP2_INV:`DCC_MODE_LO]};
    end else if (hit_flag) begin
      rd_byte[`DCC_B_IRQ_FLAG] = flag_q;
    end else if (hit_ena) begin
      rd_byte[`DCC_B_IRQ_ENA] = ena_q;
    end else if (hit_irqc) begin
      rd_byte[`DCC_B_GLOBAL_ENA] = global_ena_q;
      rd_byte[`DCC_B_PERIPH_ENA] = periph_ena_q;
    end else if (hit_dir) begin
      rd_byte = {portf_direction_q, 1'b0};
    end else if (hit_conv) begin
      rd_byte[`DCC_CONV_HI:`DCC_CONV_LO] = analog_port_config_q;
    end else if (hit_port) begin
      rd_byte = {port_rd, 1'b0};
    end
  end

  // Wishbone answer, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // control register reset only by device reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_control_q <= `DCC_RST_CTRL;
    end else begin
      comparator_control_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
    end else begin
      sync1_q <= {cmp2_above_i, cmp1_above_i};
      sync2_q <= sync1_q;
      pin_s1_q <= portf_pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_q <= 2'h0;
    end else if (ctrl_access) begin
      cap_q <= res;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Enables, direction, latch, converter config
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ena_q <= 1'b0;
      periph_ena_q <= 1'b0;
      global_ena_q <= 1'b0;
      portf_direction_q <= `DCC_RST_DIR;
      port_latch_q <= 7'h00;
      analog_port_config_q <= `DCC_RST_CONV;
    end else begin
      if (wr & hit_ena) begin
        ena_q <= wbyte[`DCC_B_IRQ_ENA];
      end
      if (wr & hit_irqc) begin
        periph_ena_q <= wbyte[`DCC_B_PERIPH_ENA];
        global_ena_q <= wbyte[`DCC_B_GLOBAL_ENA];
      end
      if (wr & hit_dir) begin
        portf_direction_q <= wbyte[7:1];
      end
      if (wr & hit_port) begin
        port_latch_q <= wbyte[7:1];
      end
      if (wr & hit_conv) begin
        analog_port_config_q <= wbyte[`DCC_CONV_HI:`DCC_CONV_LO];
      end
    end
  end

  // Registered side outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      out_q <= 7'h00;
      oe_n_q <= `DCC_RST_DIR;
      cmp1_on_q <= 1'b0;
      cmp2_on_q <= 1'b0;
      neg_q <= 2'h0;
      ref_q <= 1'b0;
      analog_q <= ~`DCC_RST_CONV;
    end else begin
      irq_q <= irq_d;
      // wake from sleep on enabled flag
      wake_q <= flag_q & ena_q;
      out_q <= out_d;
      oe_n_q <= portf_direction_q;
      cmp1_on_q <= ~mode_off;
      cmp2_on_q <= ~mode_off;
      neg_q <= neg_d;
      ref_q <= mode_mux4;
      analog_q <= analog_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  // lines 1 and 2 bypass the clock in pin modes
  assign portf_out_o = mode_pin ? out_d : out_q;
  assign portf_oe_n_o = oe_n_q;
  assign cmp1_on_o = cmp1_on_q;
  assign cmp2_on_o = cmp2_on_q;
  assign cmp_neg_sel_o = neg_q;
  assign ref_to_pos_o = ref_q;
  assign analog_line_o = analog_q;
  assign irq_o = irq_q;
  assign wake_o = wake_q;

  default clocking dcc_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_polarity;
    !mode_off && !inv1 && $stable(sync2_q) |-> res1 == sync2_q[0];
  endproperty
  a_polarity: assert property (p_polarity) else $error("result polarity");

  property p_invert;
    !mode_off && inv2 |-> res2 == !sync2_q[1];
  endproperty
  a_invert: assert property (p_invert) else $error("inversion wrong");

  property p_ro_bits;
    wr && hit_ctrl |=> comparator_control_q[7:6] == 2'h0;
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("result bits stored");

  property p_mode_write;
    wr && hit_ctrl |=> mode == $past(wbyte[2:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not taken");

  property p_reset;
    @(posedge clk_i) $past(rst_i) |-> comparator_control_q == `DCC_RST_CTRL;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");

  property p_switch;
    mode_mux4 && comparator_control_q[3] |=> cmp_neg_sel_o == DCC_NEG_LINE34;
  endproperty
  a_switch: assert property (p_switch) else $error("switch routing");

  property p_ref;
    !mode_mux4 ##1 !mode_mux4 |-> !ref_to_pos_o;
  endproperty
  a_ref: assert property (p_ref) else $error("reference outside mode");

  property p_mismatch;
    mismatch |=> flag_q;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("flag missed change");

  property p_irq;
    irq_o |-> $past(flag_q) && $past(ena_q) && $past(periph_ena_q) && $past(global_ena_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enables");

  property p_off;
    mode_off |-> res == 2'h0;
  endproperty
  a_off: assert property (p_off) else $error("results not low when off");

  property p_read_race;
    ctrl_access && mismatch |=> flag_q;
  endproperty
  a_read_race: assert property (p_read_race) else $error("flag lost on access");

  property p_sw_set;
    flag_wr && wbyte[`DCC_B_IRQ_FLAG] |=> flag_q;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set ignored");

  property p_sw_clear;
    flag_wr && !wbyte[`DCC_B_IRQ_FLAG] && !mismatch |=> !flag_q;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("flag not cleared");

  property p_dir_gate;
    wr && hit_dir |-> ##2 portf_oe_n_o == $past(wbyte[7:1], 2);
  endproperty
  a_dir_gate: assert property (p_dir_gate) else $error("direction not applied");

endmodule : dcc_top

//--- logic/dcc_pad_note.sv
`timescale 1ns/1ns

//--- sim/dcc_analog_model.sv
`timescale 1ns/1ns
module dcc_analog_model (
  input wire logic ref_to_pos_i,
  input wire logic [1:0] neg_sel_i,
  input wire logic [6:0] drv_i,
  input wire logic [6:0] drv_oe_n_i,
  input wire logic [6:0] ext_i,
  output logic cmp1_above_o,
  output logic cmp2_above_o,
  output logic [6:0] pin_o
);
  int pos_mv [2] = '{100, 100};
  int neg_mv [2] = '{500, 500};
  int line_mv [7] = '{0, 0, 700, 300, 300, 700, 0};
  int vref_mv = 600;
  int p1, p2, m1, m2;
  always_comb begin
    p1 = ref_to_pos_i ? vref_mv : pos_mv[0];
    p2 = ref_to_pos_i ? vref_mv : pos_mv[1];
    m1 = neg_sel_i == 2'h2 ? line_mv[4] : neg_sel_i == 2'h1 ? line_mv[5] : neg_mv[0];
    m2 = neg_sel_i == 2'h2 ? line_mv[2] : neg_sel_i == 2'h1 ? line_mv[3] : neg_mv[1];
    cmp1_above_o = p1 > m1;
    cmp2_above_o = p2 > m2;
  end
  // Released lines follow the outside level
  assign pin_o = (drv_i & ~drv_oe_n_i) | (ext_i & drv_oe_n_i);
endmodule : dcc_analog_model

//--- sim/test_dual_comparator_control.sv
`timescale 1ns/1ns
module test_dual_comparator_control;
  typedef struct packed {
    logic [7:0] wr;
    logic [1:0] hi;
    logic [7:0] exp;
  } dcc_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [6:0] pin, out, oe_n;
  logic [6:0] ext = 7'h7f;
  logic c1, c2, on1, on2, ref_pos, irq, wake;
  logic [1:0] nsel;
  logic [3:0] aline;
  logic [7:0] q;
  int n_fail = 0;
  int tests_run = 0;
  dcc_row_t rows [8] = '{'{8'hc0, 2'b00, 8'h00}, '{8'h00, 2'b10, 8'h80},
    '{8'h00, 2'b01, 8'h40}, '{8'h30, 2'b00, 8'hf0}, '{8'h10, 2'b11, 8'h90},
    '{8'h37, 2'b11, 8'h37}, '{8'h0e, 2'b00, 8'h4e}, '{8'h06, 2'b00, 8'h86}};
  dcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp1_above_i(c1), .cmp2_above_i(c2), .portf_pin_i(pin),
    .portf_out_o(out), .portf_oe_n_o(oe_n), .cmp1_on_o(on1), .cmp2_on_o(on2),
    .cmp_neg_sel_o(nsel), .ref_to_pos_o(ref_pos), .analog_line_o(aline), .irq_o(irq),
    .wake_o(wake));
  dcc_analog_model m (.ref_to_pos_i(ref_pos), .neg_sel_i(nsel), .drv_i(out),
    .drv_oe_n_i(oe_n), .ext_i(ext), .cmp1_above_o(c1), .cmp2_above_o(c2), .pin_o(pin));
  always #5 clk_i = ~clk_i;
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, wb_ack_o, 1'b1);
    end
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      m.pos_mv[0] <= rows[i].hi[0] ? 900 : 100;
      m.pos_mv[1] <= rows[i].hi[1] ? 900 : 100;
      bus(1'b1, 8'h00, rows[i].wr);
      repeat (3) @(posedge clk_i);
      bus(1'b0, 8'h00, 8'h00);
      chk(q, rows[i].exp);
    end
    chk({6'h0, nsel}, 8'h01);
    chk({7'h0, ref_pos}, 8'h01);
    bus(1'b1, 8'h00, 8'h0e);
    chk({6'h0, nsel}, 8'h02);
    chk({4'h0, aline}, 8'h0f);
    bus(1'b0, 8'h18, 8'h00);
    chk(q, 8'h86);
    bus(1'b1, 8'h14, 8'h0f);
    bus(1'b0, 8'h18, 8'h00);
    chk(q, 8'hfe);
    bus(1'b0, 8'h20, 8'h00);
    chk(q, 8'h00);
    // Write without lane 0 enable is ignored
    sel <= 4'h0;
    bus(1'b1, 8'h14, 8'h00);
    sel <= 4'h1;
    bus(1'b0, 8'h18, 8'h00);
    chk(q, 8'hfe);
    bus(1'b1, 8'h10, 8'hf8);
    chk({1'b0, oe_n}, 8'h7c);
    bus(1'b1, 8'h00, 8'h03);
    m.pos_mv[0] <= 900;
    m.pos_mv[1] <= 100;
    #1;
    chk({6'h0, out[1:0]}, 8'h01);
    @(posedge clk_i);
    // Mode change while the interrupt is still masked
    bus(1'b1, 8'h00, 8'h00);
    chk({6'h0, on2, on1}, 8'h03);
    bus(1'b1, 8'h08, 8'h40);
    bus(1'b1, 8'h0c, 8'hc0);
    bus(1'b1, 8'h04, 8'h00);
    m.pos_mv[1] <= 900;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h04, 8'h00);
    chk(q, 8'h40);
    chk({6'h0, irq, wake}, 8'h03);
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b0, 8'h04, 8'h00);
    chk(q, 8'h40);
    bus(1'b0, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b0, 8'h04, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, 8'h04, 8'h40);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, 8'h0c, 8'h40);
    bus(1'b0, 8'h04, 8'h00);
    chk({7'h0, irq}, 8'h00);
    chk(q, 8'h40);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b1, 8'h00, 8'h15);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h00, 8'h00);
    chk(q, 8'h07);
    chk({6'h0, on2, on1}, 8'h00);
    final_report;
  end
endmodule : test_dual_comparator_control
